// ==== core/dps_seq.sv ====
// Dual rail power sequencer: mode control, channel start-up, fault latches
//
// Operation
// - Channel starts when its enable trip high
// - New channel waits behind running soft-start
// - Both trips within window start together
// - Power-up goes to discharge after reference valid
// - Run while master high and channel enabled
// - Filtered over-voltage latches, low drives high
// - Under-voltage after blanking latches, drives low
// - Standby or shutdown discharges still-high rails
// - Master high, trip low keeps converter off
// - Over-temperature latches everything off until toggle
// - Shutdown turns reference and all rails off
// - Soft-start lasts fixed time, then releases waiter
// - Discharge on trip low or under-voltage latch
// - Over-voltage must persist before latching
module dps_seq
	import dps_pkg::*;
#(
	parameter logic [dps_pkg::CNT_W-1:0] SS_CYC = dps_pkg::SS_CYC_DEF,
	parameter logic [dps_pkg::CNT_W-1:0] BLANK_CYC = dps_pkg::BLANK_CYC_DEF
) (
	input wire logic pclk, // Block clock, 20 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic master_enable, // Master enable pin
	input wire logic channel1_enable_trip, // Channel 1 above threshold
	input wire logic channel2_enable_trip, // Channel 2 above threshold
	input wire logic output_rail1_ov, // Rail 1 above 111 percent
	input wire logic output_rail2_ov, // Rail 2 above 111 percent
	input wire logic output_rail1_uv, // Rail 1 below 52 percent
	input wire logic output_rail2_uv, // Rail 2 below 52 percent
	input wire logic linear_rail_lockout, // Linear rails under lockout
	input wire logic ref_valid, // Reference valid
	input wire logic over_temp, // Junction above 150 C
	input wire logic output_rail1_high, // Rail 1 still charged
	input wire logic output_rail2_high, // Rail 2 still charged
	output logic ref_en, // Reference on
	output logic linear_rail_5v_en, // 5 V linear regulator on
	output logic linear_rail_3v3_en, // 3.3 V linear regulator on
	output logic [1:0] converter_en, // Channel switching allowed
	output logic [1:0] soft_start, // Channel in soft-start
	output logic low_side_drive_force_high, // Both low drives forced on
	output logic gate_drive_force_low, // All drives forced off
	output logic [1:0] discharge_en, // Discharge switch closed
	output logic irq // Level interrupt
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic [IN_W-1:0] raw; // Unsynchronised flags
	logic [IN_W-1:0] sy; // Synchronised flags
	logic [IN_W-1:0] sy_prev_q; // Previous synchronised flags

	assign raw = {output_rail2_high, output_rail1_high, over_temp,
		ref_valid, linear_rail_lockout, output_rail2_uv, output_rail1_uv,
		output_rail2_ov, output_rail1_ov, channel2_enable_trip,
		channel1_enable_trip, master_enable};

	dps_sync #(.WIDTH(IN_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(raw),
		.dout(sy)
	);

	// Edge history
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sy_prev_q <= '0;
		else
			sy_prev_q <= sy;

	logic [1:0] trip; // Per-channel trip level
	logic [1:0] trip_rise; // Trip rising edge
	logic [1:0] ov_in; // Over-voltage flags
	logic [1:0] uv_in; // Under-voltage flags
	logic [1:0] hi_in; // Rail still high
	logic toggle; // Any enable fell
	assign trip = {sy[IN_TRIP2], sy[IN_TRIP1]};
	assign trip_rise = trip & ~{sy_prev_q[IN_TRIP2], sy_prev_q[IN_TRIP1]};
	assign ov_in = {sy[IN_OV2], sy[IN_OV1]};
	assign uv_in = {sy[IN_UV2], sy[IN_UV1]};
	assign hi_in = {sy[IN_HI2], sy[IN_HI1]};
	assign toggle = |(sy_prev_q[2:0] & ~sy[2:0]);

	////////////////////////////////////////////////////////////////////////
	// Registers and state
	logic [31:0] ctrl_q; // Control register
	logic [IRQ_W-1:0] irq_stat_q; // Sticky events
	logic [IRQ_W-1:0] irq_mask_q; // Event mask
	dps_mode_e mode_q; // Operating mode
	dps_mode_e mode_d; // Next mode
	dps_ch_e ch_q [2]; // Channel states
	logic [CNT_W-1:0] ss_cnt_q [2]; // Soft-start timers
	logic [CNT_W-1:0] win_q [2]; // Coincidence timers
	logic [CNT_W-1:0] blank_q [2]; // Blanking timers
	logic [CNT_W-1:0] ovf_q; // Over-voltage filter count
	logic ov_lat_q; // Over-voltage latch
	logic uv_lat_q; // Under-voltage latch
	logic ot_lat_q; // Over-temperature latch
	logic conv_allow; // Converters may run
	logic [1:0] ss_done; // Soft-start finishing this cycle
	logic ov_set; // Over-voltage latch sets
	logic uv_set; // Under-voltage latch sets
	logic [1:0] need_dis; // Rail needs discharge

	// True for the mode groups that keep the reference up
	function automatic logic ref_on(input dps_mode_e m);
		ref_on = (m != MODE_SHUTDOWN) && (m != MODE_OTSD);
	endfunction : ref_on

	// Next value of a down counter that stops at zero
	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] c);
		dec = (c != '0) ? c - CNT_W'(1) : c;
	endfunction : dec

	assign conv_allow = sy[IN_MEN] && ctrl_q[CTRL_GATE_BIT] &&
		!sy[IN_LOCK] && !ov_lat_q && !uv_lat_q && !ot_lat_q &&
		(mode_q != MODE_PWRUP);

	////////////////////////////////////////////////////////////////////////
	// Channel sequencers
	always_comb
		for (int i = 0; i < 2; i++)
			ss_done[i] = (ch_q[i] == CH_SS) && (ss_cnt_q[i] == CNT_W'(1));

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			for (int i = 0; i < 2; i++)
			begin
				ch_q[i] <= CH_OFF;
				ss_cnt_q[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				case (ch_q[i])
					CH_OFF:
						// Start, or queue behind a running soft-start
						if (conv_allow && trip[i])
						begin
							if (ch_q[1-i] == CH_SS && win_q[1-i] == '0 &&
								!ss_done[1-i])
								ch_q[i] <= CH_WAIT;
							else
							begin
								ch_q[i] <= CH_SS;
								ss_cnt_q[i] <= SS_CYC;
							end
						end
					CH_WAIT:
						// Released when the other soft-start ends
						if (!conv_allow || !trip[i])
							ch_q[i] <= CH_OFF;
						else if (ch_q[1-i] != CH_SS || ss_done[1-i])
						begin
							ch_q[i] <= CH_SS;
							ss_cnt_q[i] <= SS_CYC;
						end
					CH_SS:
						// Ramp timer
						if (!conv_allow || !trip[i])
							ch_q[i] <= CH_OFF;
						else if (ss_done[i])
							ch_q[i] <= CH_ON;
						else
							ss_cnt_q[i] <= dec(ss_cnt_q[i]);
					CH_ON:
						// Regulating
						if (!conv_allow || !trip[i])
							ch_q[i] <= CH_OFF;
					default:
						ch_q[i] <= CH_OFF;
				endcase
			end
		end

	// Coincidence and blanking timers, both restarted by a trip rise
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			for (int i = 0; i < 2; i++)
			begin
				win_q[i] <= '0;
				blank_q[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (trip_rise[i])
					win_q[i] <= COIN_CYC;
				else
					win_q[i] <= dec(win_q[i]);
				if (ch_q[i] == CH_OFF || trip_rise[i])
					blank_q[i] <= BLANK_CYC;
				else
					blank_q[i] <= dec(blank_q[i]);
			end
		end

	////////////////////////////////////////////////////////////////////////
	// Fault latches; a set in the clearing cycle wins
	assign ov_set = (ovf_q == OVF_CYC - CNT_W'(1)) && (|ov_in);
	always_comb
	begin
		uv_set = 1'b0;
		for (int i = 0; i < 2; i++)
			if (ch_q[i] != CH_OFF && blank_q[i] == '0 && uv_in[i])
				uv_set = 1'b1;
	end

	// Over-voltage persistence counter
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ovf_q <= '0;
		else if (!(|ov_in) || mode_q == MODE_PWRUP)
			ovf_q <= '0;
		else if (ovf_q != OVF_CYC)
			ovf_q <= ovf_q + CNT_W'(1);

	// Latches released only by reset or an enable toggle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ov_lat_q <= 1'b0;
			uv_lat_q <= 1'b0;
			ot_lat_q <= 1'b0;
		end
		else
		begin
			if (ov_set)
				ov_lat_q <= 1'b1;
			else if (toggle)
				ov_lat_q <= 1'b0;
			if (uv_set)
				uv_lat_q <= 1'b1;
			else if (toggle)
				uv_lat_q <= 1'b0;
			if (sy[IN_OT])
				ot_lat_q <= 1'b1;
			else if (toggle)
				ot_lat_q <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////
	// Mode selection
	always_comb
		for (int i = 0; i < 2; i++)
			need_dis[i] = hi_in[i] && !trip[i] && ch_q[i] == CH_OFF;

	always_comb
	begin
		mode_d = mode_q;
		if (mode_q == MODE_PWRUP)
		begin
			if (sy[IN_REF])
				mode_d = MODE_DISCH;
		end
		else if (ot_lat_q)
			mode_d = MODE_OTSD;
		else if (ov_lat_q)
			mode_d = MODE_OVP;
		else if (uv_lat_q)
			mode_d = MODE_UVP;
		else if (|need_dis && (!sy[IN_MEN] || !(|trip)))
			mode_d = MODE_DISCH;
		else if (!sy[IN_MEN])
			mode_d = MODE_SHUTDOWN;
		else if (ch_q[0] != CH_OFF || ch_q[1] != CH_OFF)
			mode_d = MODE_RUN;
		else
			mode_d = MODE_STANDBY;
	end

	// Mode register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mode_q <= MODE_PWRUP;
		else
			mode_q <= mode_d;

	////////////////////////////////////////////////////////////////////////
	// Registered control outputs
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ref_en <= 1'b0;
			linear_rail_5v_en <= 1'b0;
			linear_rail_3v3_en <= 1'b0;
			converter_en <= 2'h0;
			soft_start <= 2'h0;
			low_side_drive_force_high <= 1'b0;
			gate_drive_force_low <= 1'b0;
			discharge_en <= 2'h0;
		end
		else
		begin
			ref_en <= ref_on(mode_q);
			linear_rail_5v_en <= ref_on(mode_q);
			linear_rail_3v3_en <= ref_on(mode_q);
			for (int i = 0; i < 2; i++)
			begin
				converter_en[i] <= (mode_q == MODE_RUN) &&
					(ch_q[i] == CH_SS || ch_q[i] == CH_ON);
				soft_start[i] <= (ch_q[i] == CH_SS);
				discharge_en[i] <= hi_in[i] && ch_q[i] == CH_OFF &&
					(mode_q == MODE_DISCH || mode_q == MODE_UVP ||
					mode_q == MODE_STANDBY ||
					mode_q == MODE_SHUTDOWN);
			end
			low_side_drive_force_high <= (mode_q == MODE_OVP);
			gate_drive_force_low <= (mode_q == MODE_UVP ||
				mode_q == MODE_OTSD);
		end

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state
	logic acc; // Access phase
	logic done; // Transfer completes this edge
	logic wr; // Write takes effect
	logic hit; // Mapped address
	logic [IRQ_W-1:0] ev; // Events this cycle
	logic [IRQ_W-1:0] w1c; // Bits written with one

	assign acc = psel && penable;
	assign done = acc && pready;
	assign wr = done && pwrite;
	assign ev = {ss_done[1], ss_done[0], sy[IN_OT] && !ot_lat_q,
		uv_set && !uv_lat_q, ov_set && !ov_lat_q};
	assign w1c = (wr && paddr == IRQ_STAT_OFS) ? pwdata[IRQ_W-1:0] : '0;

	always_comb
		if (paddr == CTRL_OFS)
			hit = 1'b1;
		else if (paddr == STAT_OFS)
			hit = 1'b1;
		else if (paddr == IRQ_STAT_OFS)
			hit = 1'b1;
		else if (paddr == IRQ_MASK_OFS)
			hit = 1'b1;
		else
			hit = 1'b0;

	// Ready, error and read data answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready && !pwrite)
			begin
				if (paddr == CTRL_OFS)
					prdata <= ctrl_q;
				else if (paddr == STAT_OFS)
					prdata <= {13'h0000, ot_lat_q, uv_lat_q, ov_lat_q,
						ch_q[1], ch_q[0], mode_q};
				else if (paddr == IRQ_STAT_OFS)
					prdata <= {27'h0000000, irq_stat_q};
				else if (paddr == IRQ_MASK_OFS)
					prdata <= {27'h0000000, irq_mask_q};
				else
					prdata <= '0;
			end
			else
				prdata <= '0;
		end

	// Writable registers
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_q <= CTRL_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end
		else
		begin
			if (wr && paddr == CTRL_OFS)
				ctrl_q <= {31'h00000000, pwdata[CTRL_GATE_BIT]};
			if (wr && paddr == IRQ_MASK_OFS)
				irq_mask_q <= pwdata[IRQ_W-1:0];
		end

	// Sticky events, set wins over write-one-clear
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~w1c) | ev;

	// Interrupt level
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);

endmodule : dps_seq

// ==== core/dps_pkg.sv ====
// Constants, register map and state types of the dual rail power sequencer
package dps_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_HZ = 20_000_000; // Block clock rate
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ; // Clock period in ns
	localparam int CNT_W = 17; // Width of the long timers
	localparam int SS_TIME_US = 2000; // Soft-start duration
	localparam int BLANK_TIME_US = 3000; // Under-voltage blanking time
	localparam int COIN_TIME_NS = 60_000; // Coincidence window, longest
	localparam int OVF_TIME_NS = 5000; // Over-voltage filter, least
	localparam logic [CNT_W-1:0] SS_CYC_DEF =
		CNT_W'(SS_TIME_US * 1000 / CLK_NS); // Soft-start cycles
	localparam logic [CNT_W-1:0] BLANK_CYC_DEF =
		CNT_W'(BLANK_TIME_US * 1000 / CLK_NS); // Blanking cycles
	localparam logic [CNT_W-1:0] COIN_CYC =
		CNT_W'(COIN_TIME_NS / CLK_NS); // Window, rounded down
	localparam logic [CNT_W-1:0] OVF_CYC =
		CNT_W'((OVF_TIME_NS + CLK_NS - 1) / CLK_NS); // Filter, rounded up

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam logic [11:0] CTRL_OFS = 12'h000; // Control
	localparam logic [11:0] STAT_OFS = 12'h004; // Live status
	localparam logic [11:0] IRQ_STAT_OFS = 12'h008; // Sticky events
	localparam logic [11:0] IRQ_MASK_OFS = 12'h00c; // Event mask
	localparam logic [31:0] CTRL_RST = 32'h0000_0001; // Gate open
	localparam logic [4:0] IRQ_MASK_RST = 5'h00; // All masked
	localparam int CTRL_GATE_BIT = 0; // Software enable gate
	localparam int IRQ_W = 5; // Number of event bits
	localparam int EV_OV = 0; // Over-voltage latched
	localparam int EV_UV = 1; // Under-voltage latched
	localparam int EV_OT = 2; // Over-temperature latched
	localparam int EV_SS1 = 3; // Channel 1 soft-start done
	localparam int EV_SS2 = 4; // Channel 2 soft-start done

	////////////////////////////////////////////////////////////////////////
	// Synchronised input bit positions
	localparam int IN_W = 12; // Number of synchronised flags
	localparam int IN_MEN = 0; // Master enable
	localparam int IN_TRIP1 = 1; // Channel 1 enable trip
	localparam int IN_TRIP2 = 2; // Channel 2 enable trip
	localparam int IN_OV1 = 3; // Rail 1 over-voltage
	localparam int IN_OV2 = 4; // Rail 2 over-voltage
	localparam int IN_UV1 = 5; // Rail 1 under-voltage
	localparam int IN_UV2 = 6; // Rail 2 under-voltage
	localparam int IN_LOCK = 7; // Linear rails under lockout
	localparam int IN_REF = 8; // Reference valid
	localparam int IN_OT = 9; // Junction over temperature
	localparam int IN_HI1 = 10; // Rail 1 still high
	localparam int IN_HI2 = 11; // Rail 2 still high

	////////////////////////////////////////////////////////////////////////
	// State types
	typedef enum logic [7:0] {
		MODE_PWRUP = 8'h01,
		MODE_DISCH = 8'h02,
		MODE_STANDBY = 8'h04,
		MODE_RUN = 8'h08,
		MODE_SHUTDOWN = 8'h10,
		MODE_OVP = 8'h20,
		MODE_UVP = 8'h40,
		MODE_OTSD = 8'h80
	} dps_mode_e;

	typedef enum logic [3:0] {
		CH_OFF = 4'h1,
		CH_WAIT = 4'h2,
		CH_SS = 4'h4,
		CH_ON = 4'h8
	} dps_ch_e;

endpackage : dps_pkg

// ==== core/dps_sync.sv ====
// Three-stage input synchroniser with agreement filter
module dps_sync #(
	parameter int WIDTH = 1 // Number of flags
) (
	input wire logic pclk, // Block clock
	input wire logic presetn, // Async reset, active low
	input wire logic [WIDTH-1:0] din, // Asynchronous flags
	output logic [WIDTH-1:0] dout // Filtered flags
);

	logic [WIDTH-1:0] s1_q; // First stage, read by s2 only
	logic [WIDTH-1:0] s2_q; // Second stage
	logic [WIDTH-1:0] s3_q; // Third stage
	logic [WIDTH-1:0] out_q; // Accepted level

	////////////////////////////////////////////////////////////////////////
	// Shift chain; a bit changes once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
		end

	assign dout = out_q;

endmodule : dps_sync

// ==== tb/dps_seq_chk.sv ====
// Port checker for the dual rail power sequencer
module dps_seq_chk
	import dps_pkg::*;
#(
	parameter logic [dps_pkg::CNT_W-1:0] SS_CYC = dps_pkg::SS_CYC_DEF
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access
	input wire logic pready, // APB ready
	input wire logic master_enable, // Master enable
	input wire logic over_temp, // Hot flag
	input wire logic output_rail1_ov, // Rail 1 high
	input wire logic output_rail2_ov, // Rail 2 high
	input wire logic ref_en, // Reference on
	input wire logic [1:0] converter_en, // Channels on
	input wire logic [1:0] soft_start, // Soft-start
	input wire logic low_side_drive_force_high, // Low drives on
	input wire logic gate_drive_force_low, // Drives off
	input wire logic [1:0] discharge_en // Discharge on
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [CNT_W-1:0] ss0_q; // Channel 1 soft-start age
	logic [7:0] ov_q; // Over-voltage persistence

	////////////////////////////////////////////////////////////////////
	// Age of the running channel 1 soft-start
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ss0_q <= '0;
		else if (soft_start[0])
			ss0_q <= ss0_q + 1'b1;
		else
			ss0_q <= '0;

	// Cycles of unbroken over-voltage, saturating
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ov_q <= '0;
		else if (!(output_rail1_ov || output_rail2_ov))
			ov_q <= '0;
		else if (ov_q != 8'hff)
			ov_q <= ov_q + 8'h01;

	////////////////////////////////////////////////////////////////////
	// Properties
	chk_apb_wait: assert property (psel && $rose(penable) |=>
		pready ##1 !pready) else $error("APB answer timing wrong");
	chk_drive_excl: assert property (low_side_drive_force_high |->
		!gate_drive_force_low && ref_en) else $error("Bad ovp drives");
	chk_shut_off: assert property ($fell(master_enable) ##1
		!master_enable[*8] |-> !ref_en && converter_en == 2'b00)
		else $error("Shutdown left circuits on");
	chk_ot_off: assert property (over_temp[*8] |=>
		!ref_en && converter_en == 2'b00) else $error("Hot but on");
	chk_ss_len: assert property ($fell(soft_start[0]) &&
		converter_en[0] |-> ss0_q == SS_CYC)
		else $error("Soft-start length wrong");
	chk_coin_win: assert property ($rose(soft_start[1]) &&
		soft_start[0] |-> ss0_q <= COIN_CYC + 1'b1)
		else $error("Overlap outside window");
	chk_disch_off: assert property (discharge_en != 2'b00 |->
		(discharge_en & converter_en) == 2'b00)
		else $error("Discharge while switching");
	chk_ov_filter: assert property ($rose(low_side_drive_force_high)
		|-> ov_q >= OVF_CYC[7:0]) else $error("Ovp not filtered");
endmodule : dps_seq_chk

bind dps_seq dps_seq_chk #(.SS_CYC(SS_CYC)) chk_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.master_enable(master_enable), .over_temp(over_temp),
	.output_rail1_ov(output_rail1_ov), .output_rail2_ov(output_rail2_ov),
	.ref_en(ref_en), .converter_en(converter_en), .soft_start(soft_start),
	.low_side_drive_force_high(low_side_drive_force_high),
	.gate_drive_force_low(gate_drive_force_low),
	.discharge_en(discharge_en));

// ==== tb/dps_host_model.sv ====
// Supply model: reference, linear rails and output rails
module dps_host_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic ref_en, // Reference on
	input wire logic lin5_en, // 5 V rail on
	input wire logic lin3_en, // 3.3 V rail on
	input wire logic [1:0] conv_en, // Converters on
	input wire logic [1:0] dis_en, // Discharge on
	output logic ref_valid, // Reference settled
	output logic lockout, // Linear rails low
	output logic [1:0] rail_high // Outputs charged
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ref_q; // Reference settle pipe

	// Reference settles three cycles after enable
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ref_q <= 3'h0;
		else
			ref_q <= {ref_q[1:0], ref_en};
	assign ref_valid = ref_q[2];

	// Lockout holds until both linear rails are up
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			lockout <= 1'b1;
		else
			lockout <= !(lin5_en && lin3_en);

	// Rail charges while switching, drains when discharged
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rail_high <= 2'h0;
		else
			rail_high <= (rail_high | conv_en) & ~dis_en;
endmodule : dps_host_model

// ==== tb/dual_rail_power_sequencer_tb_top.sv ====
// Testbench for the dual rail power sequencer
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITF(c) begin for (int n = 0; n < 4000 && !(c); n++) \
	@(posedge pclk); if ((c) !== 1'b1) err_count++; end
module dual_rail_power_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dps_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr; // APB address
	logic [31:0] pwdata, prdata, rd; // APB data
	logic men, trip1, trip2, ov1, ov2, uv1, uv2, ot; // Bench levels
	logic ref_valid, lockout, ref_en, l5, l3, lsh, gfl, irq; // Flags
	logic [1:0] rail_high, conv, ss, dis; // Per-channel flags
	int err_count, num_checks; // Tallies

	dps_seq #(.SS_CYC(17'd1300), .BLANK_CYC(17'd1500)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .master_enable(men),
		.channel1_enable_trip(trip1), .channel2_enable_trip(trip2),
		.output_rail1_ov(ov1), .output_rail2_ov(ov2),
		.output_rail1_uv(uv1), .output_rail2_uv(uv2),
		.linear_rail_lockout(lockout), .ref_valid(ref_valid),
		.over_temp(ot), .output_rail1_high(rail_high[0]),
		.output_rail2_high(rail_high[1]), .ref_en(ref_en),
		.linear_rail_5v_en(l5), .linear_rail_3v3_en(l3),
		.converter_en(conv), .soft_start(ss),
		.low_side_drive_force_high(lsh), .gate_drive_force_low(gfl),
		.discharge_en(dis), .irq(irq));
	dps_host_model host_u (.pclk(pclk), .presetn(presetn),
		.ref_en(ref_en), .lin5_en(l5), .lin3_en(l3), .conv_en(conv),
		.dis_en(dis), .ref_valid(ref_valid), .lockout(lockout),
		.rail_high(rail_high));

	////////////////////////////////////////////////////////////////////
	// Clock and bus tasks
	always #25 pclk = ~pclk;

	task step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	// One APB transfer, result left in rd and er
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Verdict and end of run
	task stop_test();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// Watchdog against a hang
	initial
	begin
		#1_000_000;
		err_count++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{men, trip1, trip2, ov1, ov2, uv1, uv2, ot} = '0;
		err_count = 0;
		num_checks = 0;
		step(8);
		presetn <= 1'b1;
		step(1);
		// Reset values, unmapped place, mask
		apb(0, CTRL_OFS, 0); `CHK(rd, CTRL_RST)
		apb(0, IRQ_MASK_OFS, 0); `CHK(rd[4:0], IRQ_MASK_RST)
		apb(1, 12'h010, 32'hffff_ffff); `CHK(er, 1'b1)
		apb(0, 12'h010, 0); `CHK({er, rd}, {1'b1, 32'h0})
		apb(1, IRQ_MASK_OFS, 32'h1f);
		`CHK(irq, 1'b0)
		// Master low after power-up: shutdown
		step(30);
		apb(0, STAT_OFS, 0); `CHK(rd[7:0], MODE_SHUTDOWN)
		`CHK(ref_en, 1'b0)
		// Master high, no trips: standby
		men <= 1'b1;
		`WAITF(ref_en && l5 && l3)
		step(20);
		apb(0, STAT_OFS, 0); `CHK(rd[7:0], MODE_STANDBY)
		`CHK({ref_en, l5, l3, conv}, 5'h1c)
		// Close enables start together
		trip1 <= 1'b1;
		step(100);
		trip2 <= 1'b1;
		step(12);
		`CHK(ss, 2'b11)
		`WAITF(ss == 2'b00)
		step(4);
		`CHK(conv, 2'b11)
		apb(0, STAT_OFS, 0); `CHK(rd[7:0], MODE_RUN)
		apb(0, IRQ_STAT_OFS, 0); `CHK(rd[4:0], 5'h18)
		`CHK(irq, 1'b1)
		apb(1, IRQ_STAT_OFS, 32'h18);
		`CHK(irq, 1'b0)
		apb(1, IRQ_MASK_OFS, 32'h07);
		// Gate cleared stops both converters, set restarts them
		apb(1, CTRL_OFS, 32'h0);
		step(3);
		`CHK(conv, 2'b00)
		apb(1, CTRL_OFS, 32'h1);
		step(20);
		`CHK(conv, 2'b11)
		// Trips low: discharge mode drains the rails
		trip1 <= 1'b0;
		trip2 <= 1'b0;
		`WAITF(dis[1])
		`CHK(dis[1], 1'b1)
		`WAITF(dis == 2'b00)
		`CHK(rail_high, 2'b00)
		// Late second enable waits behind the first
		trip1 <= 1'b1;
		step(3);
		`CHK(ss, 2'b00)
		step(1247);
		`CHK(ss, 2'b01)
		trip2 <= 1'b1;
		step(20);
		`CHK(ss, 2'b01)
		apb(0, STAT_OFS, 0); `CHK(rd[15:12], 4'h2)
		`WAITF(!ss[0])
		step(3);
		`CHK(ss, 2'b10)
		`CHK(irq, 1'b0)
		`WAITF(ss == 2'b00)
		// Brief over-voltage filtered, long one latches
		ov1 <= 1'b1;
		step(50);
		ov1 <= 1'b0;
		step(20);
		`CHK(lsh, 1'b0)
		ov1 <= 1'b1;
		step(120);
		`CHK({lsh, ref_en, irq}, 3'h7)
		apb(0, STAT_OFS, 0); `CHK(rd[7:0], MODE_OVP)
		ov1 <= 1'b0;
		step(20);
		`CHK(lsh, 1'b1)
		trip1 <= 1'b0;
		step(10);
		trip1 <= 1'b1;
		step(10);
		`CHK(lsh, 1'b0)
		// Under-voltage inside blanking is ignored
		uv1 <= 1'b1;
		step(30);
		uv1 <= 1'b0;
		`CHK(gfl, 1'b0)
		step(1700);
		uv2 <= 1'b1;
		`WAITF(gfl)
		`CHK({gfl, conv}, 3'h4)
		apb(0, STAT_OFS, 0); `CHK(rd[17], 1'b1)
		uv2 <= 1'b0;
		// Master low clears the latch, reference off
		men <= 1'b0;
		step(20);
		`CHK({ref_en, gfl}, 2'b00)
		men <= 1'b1;
		`WAITF(conv == 2'b11)
		// Over-temperature latches all off until a toggle
		ot <= 1'b1;
		step(10);
		ot <= 1'b0;
		step(20);
		`CHK({ref_en, l5, conv}, 4'h0)
		men <= 1'b0;
		step(10);
		men <= 1'b1;
		`WAITF(ref_en)
		`CHK(ref_en, 1'b1)
		stop_test();
	end
endmodule : dual_rail_power_sequencer_tb_top
